/* sbcwd_regs.vh */
`ifndef SBCWD_REGS_VH
`define SBCWD_REGS_VH

// ============================================================
// Clock and time base
`define SBCWD_CLK_KHZ        20000
`define SBCWD_TICK_MS        1
`define SBCWD_LONG_OPEN_MS   10'd200
`define SBCWD_CLOSED_PCT     17'd60

// ============================================================
// Chip modes seen by the watchdog
`define SBCWD_MODE_INIT      3'h0
`define SBCWD_MODE_NORMAL    3'h1
`define SBCWD_MODE_STOP      3'h2
`define SBCWD_MODE_SLEEP     3'h3
`define SBCWD_MODE_RESTART   3'h4
`define SBCWD_MODE_FAILSAFE  3'h5

// ============================================================
// trigger_control_reg fields
`define SBCWD_TRG_PARITY     7
`define SBCWD_TRG_TYPE       6
`define SBCWD_TRG_ARM_B      5
`define SBCWD_TRG_RSVD       3
`define SBCWD_TRG_PER_HI     2
`define SBCWD_TRG_PER_LO     0

// ============================================================
// wake_control_reg_one fields
`define SBCWD_WK_ARM_A       0
`define SBCWD_WK_BUS_EN      1

// ============================================================
// Reset values
`define SBCWD_RST_TYPE       1'b0
`define SBCWD_RST_PERIOD     3'h1
`define SBCWD_RST_BUS_EN     1'b1
`define SBCWD_RST_FAIL       2'h0

// ============================================================
// Fail counter ceilings
`define SBCWD_FAIL_CAP_CFG2  2'h1
`define SBCWD_FAIL_CAP_OTHER 2'h2
`define SBCWD_CFG2_CODE      2'h1

`endif

/* sbcwd_watchdog.v */
`timescale 1ns/1ps
`include "sbcwd_regs.vh"

module sbcwd_watchdog #(
  parameter TICK_CYCLES = `SBCWD_CLK_KHZ * `SBCWD_TICK_MS
) (
  input  wire       MCLK,
  input  wire       RSTN,
  input  wire       CHIP_SELECT_N,
  input  wire       TRIG_WR,
  input  wire [7:0] TRIG_DATA,
  input  wire       WAKE_WR,
  input  wire [1:0] WAKE_DATA,
  input  wire [2:0] CHIP_MODE,
  input  wire       DEV_MODE,
  input  wire [1:0] FAIL_CONFIG,
  input  wire       RO_HIGH,
  input  wire       BUS_WAKE,
  output reg        WD_RESET_REQ,
  output reg        GO_FAILSAFE,
  output reg  [1:0] FAIL_COUNT,
  output reg        WATCH_TYPE,
  output reg  [2:0] PERIOD_SELECT,
  output reg        ARM_A,
  output reg        ARM_B,
  output reg        BUS_WAKE_EN,
  output reg        SPI_FAIL,
  output reg        WD_ACTIVE,
  output reg        LONG_OPEN
);

  // ============================================================
  // Pin synchronisers
  reg        cs_meta;
  reg        cs_sync;
  reg        cs_prev;
  reg        wk_meta;
  reg        wk_sync;
  reg        wk_prev;

  always @(posedge MCLK) begin
    if (!RSTN) begin
      cs_meta <= 1'b1;
      cs_sync <= 1'b1;
      cs_prev <= 1'b1;
      wk_meta <= 1'b0;
      wk_sync <= 1'b0;
      wk_prev <= 1'b0;
    end else begin
      cs_meta <= CHIP_SELECT_N;
      cs_sync <= cs_meta;
      cs_prev <= cs_sync;
      wk_meta <= BUS_WAKE;
      wk_sync <= wk_meta;
      wk_prev <= wk_sync;
    end
  end

  wire cs_rise  = cs_sync & ~cs_prev;
  wire wake_hit = wk_sync & ~wk_prev;

  // ============================================================
  // Millisecond tick
  reg  [15:0] tick_cnt;
  wire        tick = (tick_cnt == TICK_CYCLES[15:0] - 16'h0001);

  always @(posedge MCLK) begin
    if (!RSTN)
      tick_cnt <= 16'h0000;
    else if (tick)
      tick_cnt <= 16'h0000;
    else
      tick_cnt <= tick_cnt + 16'h0001;
  end

  // ============================================================
  // Period and closed window lookup in ms
  function [9:0] period_ms;
    input [2:0] sel;
    begin
      case (sel)
        3'h1:    period_ms = 10'd10;
        3'h2:    period_ms = 10'd20;
        3'h3:    period_ms = 10'd50;
        3'h4:    period_ms = 10'd100;
        3'h5:    period_ms = 10'd200;
        3'h6:    period_ms = 10'd500;
        3'h7:    period_ms = 10'd1000;
        default: period_ms = 10'd10; // Code 0 unused, treated as shortest
      endcase
    end
  endfunction

  wire [9:0]  per_ms    = period_ms(PERIOD_SELECT);
  wire [16:0] closed_w  = {7'h00, per_ms} * `SBCWD_CLOSED_PCT;
  // Quotient never exceeds 600, so the low ten bits hold it whole
  wire [16:0] closed_q  = closed_w / 17'd100;
  wire [9:0]  closed_ms = closed_q[9:0];

  // ============================================================
  // Pending trigger write, executed at chip select release
  reg       pend;
  reg [7:0] pend_data;

  always @(posedge MCLK) begin
    if (!RSTN) begin
      pend      <= 1'b0;
      pend_data <= 8'h00;
    end else if (TRIG_WR) begin
      pend      <= 1'b1;
      pend_data <= TRIG_DATA;
    end else if (cs_rise) begin
      pend      <= 1'b0;
    end
  end

  wire exec      = pend & cs_rise;
  // Reserved bit is part of the stored byte, so it enters the parity
  wire par_ok    = ~(^pend_data);
  wire trig_ok   = exec & par_ok;
  wire is_normal = (CHIP_MODE == `SBCWD_MODE_NORMAL);
  wire is_stop   = (CHIP_MODE == `SBCWD_MODE_STOP);
  wire is_init   = (CHIP_MODE == `SBCWD_MODE_INIT);
  wire mode_off  = DEV_MODE | (CHIP_MODE == `SBCWD_MODE_SLEEP) |
                   (CHIP_MODE == `SBCWD_MODE_RESTART) | (CHIP_MODE == `SBCWD_MODE_FAILSAFE);

  // ============================================================
  // Mode and reset-release edges
  reg [2:0] mode_prev;
  reg       ro_prev;

  always @(posedge MCLK) begin
    if (!RSTN) begin
      mode_prev <= `SBCWD_MODE_INIT;
      ro_prev   <= 1'b0;
    end else begin
      mode_prev <= CHIP_MODE;
      ro_prev   <= RO_HIGH;
    end
  end

  wire ro_rise    = RO_HIGH & ~ro_prev;
  wire enter_norm = is_normal & (mode_prev != `SBCWD_MODE_NORMAL) &
                    (mode_prev != `SBCWD_MODE_INIT);
  wire from_stop  = enter_norm & (mode_prev == `SBCWD_MODE_STOP);

  // ============================================================
  // Watchdog core
  reg [9:0] ms_cnt;
  reg       stop_off;
  reg       wd_fault;
  reg [1:0] fail_cap;

  always @* begin
    fail_cap = (FAIL_CONFIG == `SBCWD_CFG2_CODE) ? `SBCWD_FAIL_CAP_CFG2 : `SBCWD_FAIL_CAP_OTHER;
  end

  wire [1:0] fail_inc  = (FAIL_COUNT == fail_cap) ? FAIL_COUNT : FAIL_COUNT + 2'h1;
  wire       limit_hit = LONG_OPEN ? (ms_cnt >= `SBCWD_LONG_OPEN_MS - 10'd1) : (ms_cnt >= per_ms - 10'd1);
  wire       expire    = WD_ACTIVE & tick & limit_hit;
  wire       early     = WD_ACTIVE & ~LONG_OPEN & WATCH_TYPE & (ms_cnt < closed_ms);
  wire       running   = WD_ACTIVE & ~mode_off;
  // Disable holds only when both arms are set as stop is entered
  wire       go_off    = is_stop & (mode_prev == `SBCWD_MODE_NORMAL) & ARM_A & ARM_B;
  wire       restart_lw = (ro_rise & (is_init | is_normal) & ~DEV_MODE) |
                          (enter_norm & ~DEV_MODE) |
                          (stop_off & is_stop & (trig_ok | (wake_hit & BUS_WAKE_EN)));
  wire       fail_now  = running & ~restart_lw & ((trig_ok & early) | expire);

  always @(posedge MCLK) begin
    if (!RSTN) begin
      ms_cnt       <= 10'd0;
      WD_ACTIVE    <= 1'b0;
      LONG_OPEN    <= 1'b0;
      stop_off     <= 1'b0;
      wd_fault     <= 1'b0;
      FAIL_COUNT   <= `SBCWD_RST_FAIL;
      WD_RESET_REQ <= 1'b0;
      GO_FAILSAFE  <= 1'b0;
      SPI_FAIL     <= 1'b0;
    end else begin
      WD_RESET_REQ <= 1'b0;
      GO_FAILSAFE  <= 1'b0;
      SPI_FAIL     <= exec & ~par_ok;
      if (tick)
        ms_cnt <= ms_cnt + 10'd1;
      if (mode_off) begin
        WD_ACTIVE <= 1'b0;
        LONG_OPEN <= 1'b0;
        stop_off  <= 1'b0;
        if ((CHIP_MODE == `SBCWD_MODE_SLEEP) ||
            ((CHIP_MODE == `SBCWD_MODE_FAILSAFE) && !wd_fault))
          FAIL_COUNT <= 2'h0;
      end else if (restart_lw) begin
        WD_ACTIVE <= 1'b1;
        LONG_OPEN <= 1'b1;
        stop_off  <= 1'b0;
        wd_fault  <= 1'b0;
        ms_cnt    <= 10'd0;
      end else if (go_off) begin
        WD_ACTIVE  <= 1'b0;
        LONG_OPEN  <= 1'b0;
        stop_off   <= 1'b1;
        FAIL_COUNT <= 2'h0;
      end else if (fail_now) begin
        WD_ACTIVE    <= 1'b0;
        LONG_OPEN    <= 1'b0;
        wd_fault     <= 1'b1;
        FAIL_COUNT   <= fail_inc;
        WD_RESET_REQ <= 1'b1;
        GO_FAILSAFE  <= (fail_inc == fail_cap);
      end else if (running && trig_ok) begin
        LONG_OPEN  <= 1'b0;
        ms_cnt     <= 10'd0;
        FAIL_COUNT <= 2'h0;
      end
    end
  end

  // ============================================================
  // Configuration and arming bits
  wire cfg_wr  = trig_ok & is_normal;
  wire arm_a_set = WAKE_WR & WAKE_DATA[`SBCWD_WK_ARM_A] & is_normal;

  always @(posedge MCLK) begin
    if (!RSTN) begin
      WATCH_TYPE    <= `SBCWD_RST_TYPE;
      PERIOD_SELECT <= `SBCWD_RST_PERIOD;
      BUS_WAKE_EN   <= `SBCWD_RST_BUS_EN;
      ARM_A         <= 1'b0;
      ARM_B         <= 1'b0;
    end else begin
      if (cfg_wr) begin
        WATCH_TYPE    <= pend_data[`SBCWD_TRG_TYPE];
        PERIOD_SELECT <= pend_data[`SBCWD_TRG_PER_HI:`SBCWD_TRG_PER_LO];
      end
      // Bus wake option is frozen once the disable sequence is under way
      if (WAKE_WR && is_normal && !ARM_A && !ARM_B)
        BUS_WAKE_EN <= WAKE_DATA[`SBCWD_WK_BUS_EN];
      if (restart_lw && (from_stop || stop_off)) begin
        ARM_A <= 1'b0;
        ARM_B <= 1'b0;
      end else begin
        if (arm_a_set)
          ARM_A <= ~ARM_A;
        else if (WAKE_WR && is_normal)
          ARM_A <= 1'b0;
        if (arm_a_set && ARM_A)
          ARM_B <= 1'b0;
        else if (cfg_wr)
          ARM_B <= pend_data[`SBCWD_TRG_ARM_B] & ARM_A;
      end
    end
  end

endmodule // sbcwd_watchdog

/* sbcwd_host_model.sv */
`timescale 1ns/1ps
module sbcwd_host_model (
  input  wire       MCLK,
  input  wire       SPI_FAIL,
  output reg        CHIP_SELECT_N,
  output reg        TRIG_WR,
  output reg  [7:0] TRIG_DATA
);
  reg fail_seen;
  initial begin
    CHIP_SELECT_N = 1'b1;
    TRIG_WR = 1'b0;
    TRIG_DATA = 8'h00;
    fail_seen = 1'b0;
  end
  // ==========================================
  // One SPI write, bad flips the parity bit
  task send(input [6:0] body, input bad);
    begin
      fail_seen = 1'b0;
      @(negedge MCLK);
      CHIP_SELECT_N = 1'b0;
      TRIG_WR = 1'b1;
      TRIG_DATA = {^body ^ bad, body};
      @(negedge MCLK);
      TRIG_WR = 1'b0;
      // Released data must not match the written byte
      TRIG_DATA = ~TRIG_DATA;
      @(negedge MCLK);
      CHIP_SELECT_N = 1'b1;
      // Returns just after the execute edge so one-cycle answers still stand
      repeat (3) begin
        @(posedge MCLK);
        #1 if (SPI_FAIL === 1'b1) fail_seen = 1'b1;
      end
    end
  endtask
endmodule // sbcwd_host_model

/* sbcwd_wd_monitor.sv */
`timescale 1ns/1ps
module sbcwd_wd_monitor #(
  parameter TICK_CYCLES = 20
) (
  input wire       MCLK,
  input wire       RSTN,
  input wire       DEV_MODE,
  input wire [2:0] CHIP_MODE,
  input wire [1:0] FAIL_CONFIG,
  input wire       WD_RESET_REQ,
  input wire       GO_FAILSAFE,
  input wire [1:0] FAIL_COUNT,
  input wire       WATCH_TYPE,
  input wire [2:0] PERIOD_SELECT,
  input wire       SPI_FAIL,
  input wire       WD_ACTIVE,
  input wire       LONG_OPEN
);
  localparam int LO_MAX = 200 * TICK_CYCLES + 30;
  int lo_cnt;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RSTN);
  always @(posedge MCLK) lo_cnt <= (RSTN && LONG_OPEN && WD_ACTIVE && !DEV_MODE) ? lo_cnt + 1 : 0;
  sequence s_dev; DEV_MODE [*3]; endsequence
  sequence s_sleep; (CHIP_MODE == 3'h3) [*3]; endsequence
  sequence s_stop; (CHIP_MODE == 3'h2) [*4]; endsequence
  property p_pair; GO_FAILSAFE |-> WD_RESET_REQ; endproperty
  a_pair: assert property (p_pair) else $error("fail-safe without reset");
  property p_req_off; WD_RESET_REQ |=> !WD_ACTIVE; endproperty
  a_req_off: assert property (p_req_off) else $error("active after failure");
  property p_spi_keep; SPI_FAIL |-> $stable(PERIOD_SELECT) && $stable(WATCH_TYPE); endproperty
  a_spi_keep: assert property (p_spi_keep) else $error("bad parity changed setup");
  property p_cap; FAIL_COUNT <= ((FAIL_CONFIG == 2'h1) ? 2'h1 : 2'h2); endproperty
  a_cap: assert property (p_cap) else $error("fail count above cap");
  property p_dev; s_dev |-> !WD_RESET_REQ; endproperty
  a_dev: assert property (p_dev) else $error("reset in development mode");
  property p_sleep; s_sleep |-> !WD_ACTIVE && FAIL_COUNT == 2'h0; endproperty
  a_sleep: assert property (p_sleep) else $error("watchdog alive in sleep");
  property p_stop; s_stop |-> $stable(PERIOD_SELECT) && $stable(WATCH_TYPE); endproperty
  a_stop: assert property (p_stop) else $error("setup changed in stop");
  property p_long; lo_cnt <= LO_MAX; endproperty
  a_long: assert property (p_long) else $error("long window too long");
endmodule // sbcwd_wd_monitor
bind sbcwd_watchdog sbcwd_wd_monitor #(.TICK_CYCLES(TICK_CYCLES)) i_mon (.MCLK(MCLK), .RSTN(RSTN),
  .DEV_MODE(DEV_MODE), .CHIP_MODE(CHIP_MODE), .FAIL_CONFIG(FAIL_CONFIG), .WD_RESET_REQ(WD_RESET_REQ),
  .GO_FAILSAFE(GO_FAILSAFE), .FAIL_COUNT(FAIL_COUNT), .WATCH_TYPE(WATCH_TYPE), .PERIOD_SELECT(PERIOD_SELECT),
  .SPI_FAIL(SPI_FAIL), .WD_ACTIVE(WD_ACTIVE), .LONG_OPEN(LONG_OPEN));

/* sbcwd_testbench.sv */
`timescale 1ns/1ps
`include "sbcwd_regs.vh"
module testbench;
  reg       mclk = 1'b0;
  reg       rstn = 1'b0;
  reg       wk_wr = 1'b0;
  reg       dev = 1'b0;
  reg       ro = 1'b0;
  reg       bw = 1'b0;
  reg [1:0] fcfg = 2'h0;
  reg [1:0] wk_d = 2'h0;
  reg [2:0] mode = `SBCWD_MODE_INIT;
  wire       chip_select_n, twr, req, fs, wt, arma, armb, bwe, spif, act, lo;
  wire [7:0] tdat;
  wire [1:0] fc;
  wire [2:0] ps;
  int        errors = 0, n_compared = 0, n;
  always #25 mclk = ~mclk;
  sbcwd_host_model i_host (.MCLK(mclk), .SPI_FAIL(spif), .CHIP_SELECT_N(chip_select_n), .TRIG_WR(twr), .TRIG_DATA(tdat));
  sbcwd_watchdog #(.TICK_CYCLES(20)) i_dut (.MCLK(mclk), .RSTN(rstn), .CHIP_SELECT_N(chip_select_n), .TRIG_WR(twr),
    .TRIG_DATA(tdat), .WAKE_WR(wk_wr), .WAKE_DATA(wk_d), .CHIP_MODE(mode), .DEV_MODE(dev),
    .FAIL_CONFIG(fcfg), .RO_HIGH(ro), .BUS_WAKE(bw), .WD_RESET_REQ(req), .GO_FAILSAFE(fs),
    .FAIL_COUNT(fc), .WATCH_TYPE(wt), .PERIOD_SELECT(ps), .ARM_A(arma), .ARM_B(armb), .BUS_WAKE_EN(bwe),
    .SPI_FAIL(spif), .WD_ACTIVE(act), .LONG_OPEN(lo));
  // ==========================================
  // Helpers
  task chk(input string s, input [2:0] e, input [2:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  task wrap_up;
    if (errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task cyc(input int k);
    repeat (k) @(negedge mclk);
  endtask
  // Catches a one-cycle pulse by sampling just after each edge
  task wait_req(input int lim);
    n = 0;
    while (req !== 1'b1 && n < lim) begin
      @(posedge mclk);
      #1 n++;
    end
  endtask
  // Plays the reset block and mode controller after a failure
  task recover(input [2:0] m);
    chk("active", 0, act);
    cyc(1);
    ro = 1'b0;
    mode = m;
    cyc(5);
    ro = 1'b1;
    mode = `SBCWD_MODE_NORMAL;
    cyc(5);
    chk("long", 1, lo);
  endtask
  task wk(input [1:0] d);
    @(negedge mclk);
    wk_wr = 1'b1;
    wk_d = d;
    @(negedge mclk);
    wk_wr = 1'b0;
  endtask
  // ==========================================
  // Scenarios
  task t_init;
    cyc(10);
    rstn = 1'b1;
    chk("type", 0, wt);
    chk("period", 1, ps);
    chk("buswake", 1, bwe);
    ro = 1'b1;
    cyc(5);
    chk("long", 1, lo);
    chk("active", 1, act);
    mode = `SBCWD_MODE_NORMAL;
  endtask
  task t_timeout;
    i_host.send(7'h01, 1'b0);
    chk("long", 0, lo);
    cyc(150);
    i_host.send(7'h01, 1'b0);
    wait_req(400);
    chk("expiry", 1, n > 175 && n < 215);
    chk("fails", 1, fc);
    chk("failsafe", 0, fs);
    recover(`SBCWD_MODE_RESTART);
  endtask
  task t_window;
    i_host.send(7'h41, 1'b0);
    chk("type", 1, wt);
    cyc(40);
    i_host.send(7'h41, 1'b0);
    wait_req(400);
    chk("closed", 1, n < 20);
    recover(`SBCWD_MODE_RESTART);
    wait_req(4400);
    chk("longtime", 1, n > 3950 && n < 4020);
    chk("fails", 2, fc);
    chk("failsafe", 1, fs);
    recover(`SBCWD_MODE_FAILSAFE);
    i_host.send(7'h49, 1'b0);
    chk("fails", 0, fc);
    cyc(155);
    i_host.send(7'h49, 1'b0);
    chk("active", 1, act);
  endtask
  task t_parity;
    i_host.send(7'h02, 1'b1);
    chk("spifail", 1, i_host.fail_seen);
    chk("period", 1, ps);
  endtask
  task t_stop;
    wk(2'h3);
    wk(2'h3);
    chk("arm_a", 0, arma);
    wk(2'h3);
    chk("arm_a", 1, arma);
    cyc(140);
    i_host.send(7'h69, 1'b0);
    chk("arm_b", 1, armb);
    mode = `SBCWD_MODE_STOP;
    cyc(6);
    chk("active", 0, act);
    i_host.send(7'h0b, 1'b0);
    chk("long", 1, lo);
    chk("arms", 0, {arma, armb});
    chk("period", 1, ps);
    mode = `SBCWD_MODE_NORMAL;
    i_host.send(7'h69, 1'b0);
    chk("arm_b", 0, armb);
  endtask
  task t_buswake_cfg2;
    wk(2'h3);
    cyc(140);
    i_host.send(7'h69, 1'b0);
    chk("arm_b", 1, armb);
    mode = `SBCWD_MODE_STOP;
    cyc(6);
    chk("active", 0, act);
    bw = 1'b1;
    cyc(6);
    chk("long", 1, lo);
    chk("active", 1, act);
    bw = 1'b0;
    mode = `SBCWD_MODE_NORMAL;
    cyc(2);
    fcfg = 2'h1;
    i_host.send(7'h41, 1'b0);
    cyc(40);
    i_host.send(7'h41, 1'b0);
    wait_req(20);
    chk("closed", 1, n < 5);
    chk("fails", 1, fc);
    chk("failsafe", 1, fs);
    recover(`SBCWD_MODE_FAILSAFE);
  endtask
  task t_sleep_dev;
    mode = `SBCWD_MODE_SLEEP;
    cyc(6);
    chk("active", 0, act);
    mode = `SBCWD_MODE_NORMAL;
    cyc(6);
    chk("long", 1, lo);
    dev = 1'b1;
    wait_req(4400);
    chk("devreset", 0, req);
  endtask
  initial begin
    t_init;
    t_timeout;
    t_window;
    t_parity;
    t_stop;
    t_buswake_cfg2;
    t_sleep_dev;
    wrap_up;
  end
  initial begin
    repeat (30000) @(posedge mclk);
    errors++;
    wrap_up;
  end
endmodule // testbench
